// *** include/smbus_free_pkg.sv ***
// Constants for the bus-free timeout and slave address match block
// Behaviour
// - Both lines high over 10 periods: free
// - Two-bit select picks timer overflow rate source
// - Own seven-bit address in bits 7:1
// - Compare only address bits whose mask is one
// - Bit 0 set accepts general call address
// - Pending START issued when free timeout expires while bus_busy is set
package smbus_free_pkg;
  localparam logic [7:0] SLAVE_ADDRESS_MATCH_OFFSET = 8'hD7;
  localparam logic [7:0] SLAVE_ADDRESS_MATCH_RESET = 8'h00;
  localparam int OWN_ADDR_MSB = 7;
  localparam int OWN_ADDR_LSB = 1;
  localparam int GENERAL_CALL_BIT = 0;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
  localparam int FREE_PERIODS = 10;
  localparam logic [1:0] SRC_TIMER0 = 2'h0;
  localparam logic [1:0] SRC_TIMER1 = 2'h1;
  localparam logic [1:0] SRC_TIMER2_HIGH = 2'h2;
  localparam logic [1:0] SRC_TIMER2_LOW = 2'h3;
  localparam logic [1:0] LINE_IDLE = 2'h3;
endpackage

// *** rtl/line_sync.sv ***
// Two-stage synchroniser for the bus pins
`timescale 1ns/100ps
module line_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // Lines reset to idle high so no false low is seen after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// *** rtl/smbus_free_match.sv ***
// Bus-free timeout, bit-rate source select and slave address match
`timescale 1ns/100ps
module smbus_free_match
  import smbus_free_pkg::*;
#(
  parameter int PERIODS = FREE_PERIODS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic free_timeout_enable,
  input wire logic [1:0] bit_rate_source_select,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_high_ovf,
  input wire logic timer2_low_ovf,
  output logic bit_rate_tick,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic bus_busy,
  input wire logic start_pending,
  output logic bus_free,
  output logic start_issue,
  input wire logic [6:0] slave_address_compare_mask,
  input wire logic hardware_ack_enable,
  input wire logic [6:0] rx_address,
  input wire logic rx_address_valid,
  output logic address_ack,
  output logic general_call_hit
);
  localparam int CW = $clog2(PERIODS + 2);
  localparam logic [CW-1:0] FREE_LIMIT = CW'(PERIODS + 1);

  logic [1:0] lines_s;
  logic [7:0] slave_address_match_r, slave_address_match_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic tick_r, tick_nxt;
  logic [CW-1:0] period_cnt_r, period_cnt_nxt;
  logic free_r, free_nxt;
  logic start_r, start_nxt;
  logic ack_r, ack_nxt;
  logic gc_r, gc_nxt;
  logic sel_ovf;
  logic both_high;
  logic [6:0] own_slave_address;
  logic general_call_accept;

  line_sync #(.W(2), .IDLE(LINE_IDLE)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({scl_in, sda_in}),
    .sync_out(lines_s)
  );

  assign both_high = &lines_s;
  assign own_slave_address = slave_address_match_r[OWN_ADDR_MSB:OWN_ADDR_LSB];
  assign general_call_accept = slave_address_match_r[GENERAL_CALL_BIT];

  // One decode for the write, the read and the checks
  function automatic logic is_match_reg(input logic [7:0] a);
    is_match_reg = a == SLAVE_ADDRESS_MATCH_OFFSET;
  endfunction

  // Masked compare; a zero mask bit lets that address bit take any value
  function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] own,
                                    input logic [6:0] mask);
    addr_hit = ((rx ^ own) & mask) == 7'h00;
  endfunction

  always_comb begin
    case (bit_rate_source_select)
      SRC_TIMER0: sel_ovf = timer0_ovf;
      SRC_TIMER1: sel_ovf = timer1_ovf;
      SRC_TIMER2_HIGH: sel_ovf = timer2_high_ovf;
      default: sel_ovf = timer2_low_ovf;
    endcase
  end

  always_comb begin
    slave_address_match_nxt = slave_address_match_r;
    rdata_nxt = 8'h00;
    if (sfr_wr && is_match_reg(sfr_addr)) begin
      slave_address_match_nxt = sfr_wdata;
    end
    if (is_match_reg(sfr_addr)) begin
      rdata_nxt = slave_address_match_r;
    end
  end

  // Counting source ticks, not clocks, keeps the timeout tied to bit rate
  always_comb begin
    tick_nxt = sel_ovf;
    period_cnt_nxt = period_cnt_r;
    free_nxt = 1'b0;
    start_nxt = 1'b0;
    if (!both_high || !free_timeout_enable) begin
      period_cnt_nxt = '0;
      // Saturating at the limit keeps bus_free to one pulse per idle stretch
    end else if (tick_r && period_cnt_r != FREE_LIMIT) begin
      period_cnt_nxt = period_cnt_r + CW'(1);
      if (period_cnt_nxt == FREE_LIMIT) begin
        free_nxt = 1'b1;
        start_nxt = start_pending && bus_busy;
      end
    end
  end

  always_comb begin
    ack_nxt = 1'b0;
    gc_nxt = 1'b0;
    if (rx_address_valid && hardware_ack_enable) begin
      // General call ignores the mask; bit 0 alone decides
      if (rx_address == GENERAL_CALL_ADDRESS) begin
        ack_nxt = general_call_accept;
        gc_nxt = general_call_accept;
      end else begin
        ack_nxt = addr_hit(rx_address, own_slave_address, slave_address_compare_mask);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slave_address_match_r <= SLAVE_ADDRESS_MATCH_RESET;
      rdata_r <= 8'h00;
    end else begin
      slave_address_match_r <= slave_address_match_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_r <= 1'b0;
      period_cnt_r <= '0;
      free_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      period_cnt_r <= period_cnt_nxt;
      free_r <= free_nxt;
      start_r <= start_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      gc_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      gc_r <= gc_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign bit_rate_tick = tick_r;
  assign bus_free = free_r;
  assign start_issue = start_r;
  assign address_ack = ack_r;
  assign general_call_hit = gc_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  reg_write_a: assert property (
    sfr_wr && is_match_reg(sfr_addr) |=> slave_address_match_r == $past(sfr_wdata, 1))
    else $error("register write lost");
  reg_other_a: assert property (
    sfr_wr && !is_match_reg(sfr_addr) |=> $stable(slave_address_match_r))
    else $error("register changed by foreign write");
  rdata_unmapped_a: assert property (
    !is_match_reg(sfr_addr) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  // The first tick after reset still shows the reset value, not the source
  source_sel_a: assert property (
    bit_rate_tick == $past(sel_ovf, 1) || $rose(reset_n))
    else $error("wrong rate source");

  free_needs_high_a: assert property (
    bus_free |-> $past(both_high, 1) && $past(tick_r, 1) && $past(free_timeout_enable, 1))
    else $error("bus free without idle lines");
  free_once_a: assert property (
    bus_free |=> !bus_free)
    else $error("bus free repeated");
  count_hold_a: assert property (
    !free_timeout_enable |=> period_cnt_r == '0 && !bus_free)
    else $error("count runs while disabled");
  low_restart_a: assert property (
    !both_high |=> period_cnt_r == '0 ##1 !bus_free)
    else $error("count not restarted on low");
  no_free_low_a: assert property (
    !both_high |=> !bus_free)
    else $error("bus free right after low line");
  start_issue_a: assert property (
    start_issue |-> bus_free && $past(start_pending, 1) && $past(bus_busy, 1))
    else $error("start issued without free timeout");
  free_start_a: assert property (
    bus_free && $past(start_pending, 1) && $past(bus_busy, 1) |-> start_issue)
    else $error("pending start not issued");

  own_addr_a: assert property (
    rx_address_valid && hardware_ack_enable && slave_address_compare_mask == 7'h7F
    && rx_address == own_slave_address && rx_address != 7'h00 |=> address_ack)
    else $error("own address not acked");
  mask_zero_a: assert property (
    rx_address_valid && hardware_ack_enable && slave_address_compare_mask == 7'h00
    && rx_address != 7'h00 |=> address_ack)
    else $error("fully masked address not acked");
  general_call_a: assert property (
    rx_address_valid && hardware_ack_enable && rx_address == 7'h00
    |=> address_ack == $past(general_call_accept, 1))
    else $error("general call decision wrong");
  gc_with_ack_a: assert property (
    general_call_hit |-> address_ack && $past(rx_address, 1) == GENERAL_CALL_ADDRESS)
    else $error("general call flag without ack");
  ack_off_a: assert property (
    !hardware_ack_enable || !rx_address_valid |=> !address_ack)
    else $error("ack without request");

  free_seen_c: cover property (bus_free);
  start_seen_c: cover property (start_issue);
  gc_seen_c: cover property (general_call_hit);
  masked_ack_c: cover property (address_ack && slave_address_compare_mask != 7'h7F);
  restart_c: cover property (period_cnt_r != '0 ##1 period_cnt_r == '0);
endmodule

// *** test/bus_peer.sv ***
// Far-side bus party: idle lines float high, a frame clocks SCL and holds SDA low
`timescale 1ns/100ps
module bus_peer (
  input wire logic frame,
  output logic scl,
  output logic sda
);
  // Pull-ups bring both lines high whenever no frame is running
  always begin
    scl = 1'b1;
    sda = 1'b1;
    wait (frame);
    sda = 1'b0;
    while (frame) begin
      #62.5 scl = ~scl;
    end
  end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for bus-free timeout, bit-rate select and address match
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("FAIL %0t got %h want %h", $time, a, b); end end
module testbench;
  import smbus_free_pkg::*;
  logic clk = 0, reset_n = 0, sfr_wr = 0, fte = 0, busy = 0, pend = 0;
  logic hae = 1, rxv = 0, frame = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] sel = 2'h0;
  logic [3:0] ovf = 4'h0;
  logic [6:0] mask = 7'h7C, rx = 7'h00;
  logic tick, free, sti, ack, gc, scl, sda;
  int fails = 0, n_tests = 0, n_free = 0, n_start = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (free === 1'b1) n_free++;
    if (sti === 1'b1) n_start++;
  end
  bus_peer u_peer (.frame(frame), .scl(scl), .sda(sda));
  smbus_free_match u_dut (.clk(clk), .reset_n(reset_n), .sfr_addr(addr), .sfr_wr(sfr_wr),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .free_timeout_enable(fte),
    .bit_rate_source_select(sel), .timer0_ovf(ovf[0]), .timer1_ovf(ovf[1]),
    .timer2_high_ovf(ovf[2]), .timer2_low_ovf(ovf[3]), .bit_rate_tick(tick),
    .scl_in(scl), .sda_in(sda), .bus_busy(busy), .start_pending(pend), .bus_free(free),
    .start_issue(sti), .slave_address_compare_mask(mask), .hardware_ack_enable(hae),
    .rx_address(rx), .rx_address_valid(rxv), .address_ack(ack), .general_call_hit(gc));
  task cyc(input int n); repeat (n) @(posedge clk); #1; endtask
  task wr(input logic [7:0] a, d); addr = a; wdata = d; sfr_wr = 1; cyc(1); sfr_wr = 0; endtask
  task rd(input logic [7:0] a, e); addr = a; cyc(1); `CHK(rdata, e) endtask
  task ovf_pulse(input int i); ovf = 4'h1 << i; cyc(1); ovf = 4'h0; endtask
  task ticks(input int n); repeat (n) begin ovf_pulse(0); cyc(1); end endtask
  // Frame length spans several link periods so the synchroniser surely sees a low
  // Frame ends between link edges so the peer's last toggle never races it
  task burst; frame = 1; #470; frame = 0; cyc(12); endtask
  task try(input logic [6:0] a, input logic ea, eg);
    rx = a; rxv = 1; cyc(1); rxv = 0;
    `CHK(ack, ea)
    `CHK(gc, eg)
    cyc(1);
  endtask
  task t_reg;
    rd(8'hD7, SLAVE_ADDRESS_MATCH_RESET);
    wr(8'hD7, 8'hB5);
    rd(8'hD7, 8'hB5);
    wr(8'hC1, 8'hFF);
    rd(8'hC1, 8'h00);
    rd(8'hD7, 8'hB5);
    $display("register test done");
  endtask
  task t_src;
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 4; i++) begin
        sel = s[1:0]; ovf_pulse(i); `CHK(tick, 1'(s == i))
        cyc(1);
      end
    end
    sel = 2'h0;
    $display("source select test done");
  endtask
  task t_match;
    try(7'h5B, 1'b1, 1'b0);
    try(7'h1A, 1'b0, 1'b0);
    mask = 7'h7F;
    try(7'h5B, 1'b0, 1'b0);
    mask = 7'h7C;
    try(7'h00, 1'b1, 1'b1);
    wr(8'hD7, 8'hB4);
    try(7'h00, 1'b0, 1'b0);
    hae = 0;
    try(7'h5A, 1'b0, 1'b0);
    hae = 1;
    $display("address match test done");
  endtask
  task t_free;
    fte = 1; busy = 1; pend = 1; burst; n_free = 0; n_start = 0;
    ticks(10); `CHK(n_free, 0)
    ticks(1); cyc(2); `CHK(n_free, 1)
    `CHK(n_start, 1)
    pend = 0; burst; ticks(6); burst; ticks(10); `CHK(n_free, 1)
    ticks(1); cyc(2); `CHK(n_free, 2)
    `CHK(n_start, 1)
    fte = 0; burst; ticks(12); `CHK(n_free, 2)
    $display("free timeout test done");
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    close_out;
  end
  initial begin
    cyc(2); reset_n = 1;
    t_reg; t_src; t_match; t_free;
    close_out;
  end
endmodule
